/* File: rtl/timing_monitor_defs.svh */
`ifndef TIMING_MONITOR_DEFS_SVH
`define TIMING_MONITOR_DEFS_SVH

// Register offsets.
`define ADDR_INPUT_CLOCK_DELAY_CONFIG 8'h03
`define ADDR_TIMING_ERROR_FLAGS 8'h19

// Field positions of the delay configuration register.
`define CFG_AUTO_BIT 7
`define CFG_ENABLE_BIT 6
`define CFG_CODE_MSB 4
`define CFG_CODE_LSB 0

// Field positions of the error flag register.
`define FLG_DATA_BIT 0
`define FLG_SYNC_BIT 1
`define FLG_KIND_BIT 2

// Reset values.
`define RST_DELAY_CODE 5'h00
`define RST_CLOCK_STATE 5'h00

// Sizes and counts.
`define DATA_WIDTH 16
`define HIST_CENTER 15
`define HIST_DEPTH 32
`define CLOCK_STATES 32
`define DELAY_CODE_MAX 5'h1f
`define DIVIDER_LAST_VALID 3'h4

`endif

/* File: rtl/timing_monitor_pkg.sv */
package timing_monitor_pkg;
   typedef logic [4:0] delay_code_type;
   typedef logic [4:0] clock_state_type;
   typedef logic [3:0] margin_type;
   typedef logic [2:0] divider_type;
   typedef logic [7:0] reg_byte_type;
   typedef logic [15:0] data_word_type;
   typedef enum logic {check_idle, check_armed} check_type;
endpackage : timing_monitor_pkg

/* File: rtl/input_timing_sync_monitor.sv */
`timescale 1ns/1ps
`include "timing_monitor_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Keep early and late margin copies of input data beside the real sample.
// - Data error when either margin copy differs from the real sample.
// - Four-bit data margin sets the copy spacing; error below that margin.
// - On data error, error kind is low for hold and high for setup.
// - Automatic bit in input_clock_delay_config bit 7 makes data errors watched continuously.
// - Automatic mode increments delay on setup error, decrements on hold error.
// - Software reads back the delay code in use, including automatic changes.
// - Manual mode never changes the programmed delay code.
// - Delay line enable resets off; delay applies only once enabled.
// - Delay code spans 00000 to 11111.
// - Manual mode checks once per configuration; margin or code change rechecks.
// - Init pulse is one clock wide and loads the clock phase preset.
// - Clock generator cycles 32 states; aligned pulses reload the same state.
// - Sync edge divider needs 1,2,4,8,16 edges; codes 101 to 111 invalid.
// - Each preset increment advances internal clocks by one clock period.
// - Four-bit sync margin; sync error flag sets below that margin.
// - Alert pin is active-low open-drain, wire-OR capable.
// - Either flag drives alert by default; each has its own mask.
// - Flags latch until timing_error_flags is read or the bits are overwritten.
module input_timing_sync_monitor (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_reg_addr,
   input wire timing_monitor_pkg::reg_byte_type i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output timing_monitor_pkg::reg_byte_type o_reg_rdata,
   input wire timing_monitor_pkg::margin_type i_data_margin_setting,
   input wire timing_monitor_pkg::margin_type i_sync_margin_setting,
   input wire timing_monitor_pkg::clock_state_type i_clock_phase_preset,
   input wire timing_monitor_pkg::divider_type i_sync_edge_divider,
   input wire logic i_data_error_mask,
   input wire logic i_sync_error_mask,
   input wire timing_monitor_pkg::data_word_type i_data,
   input wire logic i_sync,
   output logic o_data_output_clock,
   output logic o_init_pulse,
   output timing_monitor_pkg::clock_state_type o_clock_state,
   output logic o_alert_out_n,
   output logic o_alert_out_n_oe
);
   import timing_monitor_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   data_word_type data_meta;
   data_word_type data_hist [0:`HIST_DEPTH-1];
   logic sync_meta;
   logic [`HIST_DEPTH-1:0] sync_hist;
   logic auto_mode;
   logic delay_line_enable;
   delay_code_type output_clock_delay_code;
   logic data_error_flag;
   logic sync_error_flag;
   logic data_error_kind;
   clock_state_type clock_state;
   clock_state_type out_phase;
   margin_type data_margin_prev;
   check_type check_mode;
   logic [4:0] edge_count;
   logic [4:0] edge_target;
   logic check_point;
   logic setup_err;
   logic hold_err;
   logic data_err;
   logic sync_edge;
   logic sync_err;
   logic wr_cfg;
   logic wr_flags;
   logic rd_flags;
   logic code_changed;
   logic margin_changed;
   logic check_now;

   ////////////////////////////////////////////////////////////////////////////
   // Pins cross two flip-flops; the first stage feeds only the history head.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_meta <= 16'h0000;
         sync_meta <= 1'b0;
         sync_hist <= 32'h0000_0000;
         for (int i = 0; i < `HIST_DEPTH; i++) begin
            data_hist[i] <= 16'h0000;
         end
      end else begin
         data_meta <= i_data;
         sync_meta <= i_sync;
         data_hist[0] <= data_meta;
         sync_hist <= {sync_hist[`HIST_DEPTH-2:0], sync_meta};
         for (int i = 1; i < `HIST_DEPTH; i++) begin
            data_hist[i] <= data_hist[i-1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The real sample sits mid-history; older entries stand for an earlier
   // capture instant, younger ones for a later one.
   always_comb begin
      check_point = (clock_state == clock_state_type'(`HIST_CENTER));
      setup_err = (data_hist[`HIST_CENTER + i_data_margin_setting]
                   != data_hist[`HIST_CENTER]);
      hold_err = (data_hist[`HIST_CENTER - i_data_margin_setting]
                  != data_hist[`HIST_CENTER]);
      check_now = check_point && (auto_mode || check_mode == check_armed);
      data_err = check_now && (setup_err || hold_err);
      sync_edge = sync_hist[`HIST_CENTER] && !sync_hist[`HIST_CENTER+1];
      sync_err = sync_edge
                 && ((sync_hist[`HIST_CENTER - i_sync_margin_setting]
                      != sync_hist[`HIST_CENTER])
                     || (sync_hist[`HIST_CENTER + 1 + i_sync_margin_setting]
                         != sync_hist[`HIST_CENTER+1]));
      margin_changed = (i_data_margin_setting != data_margin_prev);
      edge_target = 5'h01 << i_sync_edge_divider;
   end

   // Register strobes decode on an exact address match only.
   always_comb begin
      wr_cfg = i_reg_wr && (i_reg_addr == `ADDR_INPUT_CLOCK_DELAY_CONFIG);
      wr_flags = i_reg_wr && (i_reg_addr == `ADDR_TIMING_ERROR_FLAGS);
      rd_flags = i_reg_rd && (i_reg_addr == `ADDR_TIMING_ERROR_FLAGS);
      code_changed = wr_cfg
                     && (i_reg_wdata[`CFG_CODE_MSB:`CFG_CODE_LSB] != output_clock_delay_code);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register; a software write always beats an automatic step.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         auto_mode <= 1'b0;
         delay_line_enable <= 1'b0;
         output_clock_delay_code <= `RST_DELAY_CODE;
      end else if (wr_cfg) begin
         auto_mode <= i_reg_wdata[`CFG_AUTO_BIT];
         delay_line_enable <= i_reg_wdata[`CFG_ENABLE_BIT];
         output_clock_delay_code <= i_reg_wdata[`CFG_CODE_MSB:`CFG_CODE_LSB];
      end else if (auto_mode && data_err) begin
         if (setup_err && output_clock_delay_code != `DELAY_CODE_MAX) begin
            output_clock_delay_code <= output_clock_delay_code + 5'h01;
         end else if (!setup_err && output_clock_delay_code != 5'h00) begin
            output_clock_delay_code <= output_clock_delay_code - 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Manual checking runs once after reset and once after each data margin or delay code change.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         check_mode <= check_armed;
         data_margin_prev <= 4'h0;
      end else begin
         data_margin_prev <= i_data_margin_setting;
         case (check_mode)
            check_idle: begin
               if (code_changed || margin_changed) begin
                  check_mode <= check_armed;
               end
            end
            check_armed: begin
               if (check_point && !code_changed && !margin_changed) begin
                  check_mode <= check_idle;
               end
            end
            default: begin
               check_mode <= check_idle;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error flags latch; a new error in the clearing cycle wins over the clear.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_error_flag <= 1'b0;
      end else if (data_err) begin
         data_error_flag <= 1'b1;
      end else if (rd_flags) begin
         data_error_flag <= 1'b0;
      end else if (wr_flags) begin
         data_error_flag <= i_reg_wdata[`FLG_DATA_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_error_flag <= 1'b0;
      end else if (sync_err) begin
         sync_error_flag <= 1'b1;
      end else if (rd_flags) begin
         sync_error_flag <= 1'b0;
      end else if (wr_flags) begin
         sync_error_flag <= i_reg_wdata[`FLG_SYNC_BIT];
      end
   end

   // The kind bit is status, not a flag, so it outlives a clear of the flags.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_error_kind <= 1'b0;
      end else if (data_err) begin
         data_error_kind <= setup_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read data, valid the cycle after the read strobe.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         if (i_reg_addr == `ADDR_INPUT_CLOCK_DELAY_CONFIG) begin
            o_reg_rdata <= {auto_mode, delay_line_enable, 1'b0,
                            output_clock_delay_code};
         end else if (i_reg_addr == `ADDR_TIMING_ERROR_FLAGS) begin
            o_reg_rdata <= {5'h00, data_error_kind, sync_error_flag, data_error_flag};
         end else begin
            o_reg_rdata <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sync edge counting; invalid divider codes never fire, which is safer
   // than guessing a ratio and disturbing a running clock generator.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         edge_count <= 5'h00;
         o_init_pulse <= 1'b0;
      end else begin
         o_init_pulse <= 1'b0;
         if (i_sync_edge_divider > `DIVIDER_LAST_VALID) begin
            edge_count <= 5'h00;
         end else if (sync_edge) begin
            if (edge_count + 5'h01 >= edge_target) begin
               edge_count <= 5'h00;
               o_init_pulse <= 1'b1;
            end else begin
               edge_count <= edge_count + 5'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock generator; the pulse loads the preset as the next state.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clock_state <= `RST_CLOCK_STATE;
      end else if (o_init_pulse) begin
         clock_state <= i_clock_phase_preset;
      end else begin
         clock_state <= clock_state + 5'h01;
      end
   end

   always_comb begin
      out_phase = delay_line_enable ? (clock_state - output_clock_delay_code)
                                    : clock_state;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_clock_state <= `RST_CLOCK_STATE;
      end else begin
         o_clock_state <= clock_state;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data_output_clock <= 1'b0;
      end else begin
         o_data_output_clock <= out_phase[4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Open drain: the pin value is a constant low and only the enable moves.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alert_out_n <= 1'b0;
      end else begin
         o_alert_out_n <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alert_out_n_oe <= 1'b0;
      end else begin
         o_alert_out_n_oe <= (data_error_flag && !i_data_error_mask)
                             || (sync_error_flag && !i_sync_error_mask);
      end
   end

endmodule : input_timing_sync_monitor

/* File: testbench/timing_monitor_assertions.sv */
`timescale 1ns/1ps
module timing_monitor_assertions (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire timing_monitor_pkg::reg_byte_type o_reg_rdata,
   input wire timing_monitor_pkg::clock_state_type i_clock_phase_preset,
   input wire timing_monitor_pkg::divider_type i_sync_edge_divider,
   input wire logic i_data_error_mask,
   input wire logic i_sync_error_mask,
   input wire logic o_init_pulse,
   input wire timing_monitor_pkg::clock_state_type o_clock_state,
   input wire logic o_alert_out_n,
   input wire logic o_alert_out_n_oe
);
   import timing_monitor_pkg::*;
   // The state copy settles only a few cycles after reset, so its step check waits.
   logic [1:0] up;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_pulse;
      o_init_pulse;
   endsequence
   sequence s_loaded;
      ##2 o_clock_state == $past(i_clock_phase_preset, 2);
   endsequence
   a_init_one_wide: assert property (s_pulse |=> !o_init_pulse)
      else $error("init pulse wider than one cycle");
   a_preset_load: assert property (s_pulse |-> s_loaded)
      else $error("preset not loaded after init pulse");
   a_state_step: assert property (up == 2'h3 && !$past(o_init_pulse) |=>
      o_clock_state == 5'($past(o_clock_state) + 5'h01)) else $error("state did not step");
   a_open_drain: assert property (o_alert_out_n == 1'b0)
      else $error("alert pin drives high");
   a_alert_masked: assert property ($past(i_data_error_mask && i_sync_error_mask) |->
      !o_alert_out_n_oe) else $error("masked alert pulled low");
   a_rdata_hold: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (i_reg_rd && i_reg_addr != 8'h03 &&
      i_reg_addr != 8'h19 |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_invalid_div: assert property ($past(i_sync_edge_divider) > 3'h4 |-> !o_init_pulse)
      else $error("init pulse with invalid divider");
endmodule : timing_monitor_assertions

/* File: testbench/far_side_model.sv */
`timescale 1ns/1ps
module far_side_model (
   input wire logic i_toggle,
   output logic o_sync,
   output timing_monitor_pkg::data_word_type o_data
);
   import timing_monitor_pkg::*;
   // Sync edges every 8 clocks; the divider folds them to a multiple of 32.
   // The 7 ns offset keeps each edge clear of the clock's hold window.
   initial begin
      o_sync = 1'b0;
      #7;
      forever begin
         #160 o_sync = ~o_sync;
      end
   end
   // Toggling every clock breaks the data margin on command only.
   initial begin
      o_data = 16'ha5c3;
      #13;
      forever begin
         #40;
         if (i_toggle) begin
            o_data = ~o_data;
         end
      end
   end
endmodule : far_side_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
   import timing_monitor_pkg::*;
   logic i_clk, i_rst_n, wr_s, rd_s, dmask, smask, sync, toggle, oclk, pulse, al_n, al_oe;
   logic [7:0] addr;
   reg_byte_type wdata, rdata, v;
   margin_type dmargin, smargin;
   clock_state_type preset, cstate;
   divider_type div;
   data_word_type data;
   int fails, n_tests, cnt;
   input_timing_sync_monitor dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
      .i_data_margin_setting(dmargin), .i_sync_margin_setting(smargin),
      .i_clock_phase_preset(preset), .i_sync_edge_divider(div), .i_data_error_mask(dmask),
      .i_sync_error_mask(smask), .i_data(data), .i_sync(sync), .o_data_output_clock(oclk),
      .o_init_pulse(pulse), .o_clock_state(cstate), .o_alert_out_n(al_n),
      .o_alert_out_n_oe(al_oe));
   far_side_model fsm (.i_toggle(toggle), .o_sync(sync), .o_data(data));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cyc
   task automatic chk(input string name, input reg_byte_type seen, input reg_byte_type exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input reg_byte_type d);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      cyc(1);
      wr_s = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      addr = a;
      rd_s = 1'b1;
      cyc(1);
      rd_s = 1'b0;
      cyc(1);
      v = rdata;
   endtask : rd
   task automatic wrap_up();
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // Cuts a hang short at about four times the expected run.
   initial begin
      #640000;
      fails++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {i_rst_n, wr_s, rd_s, dmask, smask, toggle, addr, wdata} = '0;
      {dmargin, smargin, preset, div} = {4'h0, 4'h0, 5'h03, 3'h2};
      fails = 0;
      n_tests = 0;
      repeat (12) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      rd(8'h19);
      chk("flags rst", v, 8'h00);
      wr(8'h05, 8'hff);
      rd(8'h05);
      chk("unmapped", v, 8'h00);
      rd(8'h03);
      chk("cfg rst", v, 8'h00);
      wr(8'h03, 8'h3f);
      rd(8'h03);
      chk("code max", v, 8'h1f);
      chk("clk off", {7'h0, oclk}, {7'h0, cstate[4]});
      wr(8'h50 ^ 8'h53, 8'h50);
      cyc(2);
      chk("clk on", {7'h0, oclk}, {7'h0, ~cstate[4]});
      toggle = 1'b1;
      cyc(40);
      rd(8'h19);
      chk("no margin", v, 8'h00);
      dmargin = 4'h1;
      cyc(40);
      rd(8'h19);
      chk("setup err", v, 8'h05);
      rd(8'h03);
      chk("manual code", v, 8'h50);
      cyc(40);
      rd(8'h19);
      chk("one check", v, 8'h04);
      for (int i = 0; i < 2; i++) begin
         {dmask, smask} = 2'h3;
         wr(8'h19, 8'h01 << i);
         cyc(3);
         chk("masked", {7'h0, al_oe}, 8'h00);
         {dmask, smask} = 2'h0;
         cyc(3);
         chk("unmasked", {7'h0, al_oe}, 8'h01);
         wr(8'h19, 8'h00);
         cyc(3);
         chk("released", {7'h0, al_oe}, 8'h00);
      end
      wr(8'h03, 8'hca);
      cyc(200);
      rd(8'h03);
      chk("auto up", {7'h0, v[4:0] > 5'h0a}, 8'h01);
      chk("auto bits", v & 8'he0, 8'hc0);
      toggle = 1'b0;
      cyc(60);
      rd(8'h19);
      wr(8'h03, 8'h40);
      cyc(40);
      rd(8'h19);
      chk("clean", v, 8'h04);
      for (int i = 0; i < 4; i++) begin
         div = 3'h2 + 3'(i);
         preset = 5'h03 + 5'(i);
         cyc(160);
         cnt = 0;
         repeat (640) begin
            cyc(1);
            cnt += int'(pulse === 1'b1);
         end
         chk("pulses", 8'(cnt), (i == 3) ? 8'h00 : 8'(20 >> i));
      end
      div = 3'h2;
      smargin = 4'h5;
      cyc(64);
      rd(8'h19);
      chk("sync err", v, 8'h06);
      smargin = 4'h0;
      rd(8'h19);
      cyc(64);
      rd(8'h19);
      chk("sync clear", v, 8'h04);
      wrap_up();
   end
endmodule : tb
bind input_timing_sync_monitor timing_monitor_assertions chk_u (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .i_clock_phase_preset(i_clock_phase_preset), .i_sync_edge_divider(i_sync_edge_divider),
   .i_data_error_mask(i_data_error_mask), .i_sync_error_mask(i_sync_error_mask),
   .o_init_pulse(o_init_pulse), .o_clock_state(o_clock_state), .o_alert_out_n(o_alert_out_n),
   .o_alert_out_n_oe(o_alert_out_n_oe));
